/* logic/nand_host_pkg.sv */
// Constants, types and decode functions of the NAND host controller
// Operation
// - Bytes go on I/O with write strobe pulses
// - Command latch marks commands, address latch addresses
// - Four address cycles, two column then two row
// - Read and program send four address cycles
// - Erase sends only the two row cycles
// - Read is 00h, address, then 30h or 35h
// - Program is 80h, address, data, 10h or 15h
// - Erase is 60h, row address, then D0h
// - Random column access stays inside the page; the host sends any 12-bit column and length, unchecked against PAGE_BYTES
// - While busy only reset and status issued
// - Host never issues undefined command codes
package nand_host_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_COPY_READ_GO = 8'h35;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_PROGRAM = 8'h80;
   localparam logic [7:0] CMD_PROGRAM_GO = 8'h10;
   localparam logic [7:0] CMD_CACHE_GO = 8'h15;
   localparam logic [7:0] CMD_COPY_PROGRAM = 8'h85;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_RAND_IN = 8'h85;
   localparam logic [7:0] CMD_RAND_OUT = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   // ----------------------------------------------------------------
   // Geometry and addressing
   // ----------------------------------------------------------------
   localparam int PAGE_COUNT = 65536;
   localparam int PAGE_BYTES = 2112;
   localparam int MAIN_BYTES = 2048;
   localparam int BLOCK_COUNT = 1024;
   localparam int COL_W = 12;
   localparam int ROW_W = 16;
   localparam int LEN_W = 12;
   localparam logic [2:0] FULL_ADDR_CYCLES = 3'h4;
   localparam logic [2:0] HALF_ADDR_CYCLES = 3'h2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int STROBE_LOW_NS = 25;
   localparam int STROBE_HIGH_NS = 15;
   localparam int BUSY_SETTLE_NS = 100;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_SETTLE_CYC =
      (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_COPY_READ = 4'h1, OP_READ_ID = 4'h2,
      OP_RESET = 4'h3, OP_STATUS = 4'h4, OP_PROGRAM = 4'h5,
      OP_CACHE_PROGRAM = 4'h6, OP_COPY_PROGRAM = 4'h7,
      OP_ERASE = 4'h8, OP_RAND_IN = 4'h9, OP_RAND_OUT = 4'ha
   } op_e;
   typedef struct packed {
      op_e op;
      logic [COL_W-1:0] column;
      logic [ROW_W-1:0] row;
      logic [LEN_W-1:0] length;
   } req_s;
   typedef struct packed {
      logic cle;
      logic ale;
      logic rd;
      logic [7:0] dat;
   } cycle_s;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] firstCmd(op_e op);
      unique case (op)
         OP_READ, OP_COPY_READ: return CMD_READ;
         OP_READ_ID: return CMD_READ_ID;
         OP_RESET: return CMD_RESET;
         OP_STATUS: return CMD_STATUS;
         OP_PROGRAM, OP_CACHE_PROGRAM: return CMD_PROGRAM;
         OP_COPY_PROGRAM: return CMD_COPY_PROGRAM;
         OP_ERASE: return CMD_ERASE;
         OP_RAND_IN: return CMD_RAND_IN;
         OP_RAND_OUT: return CMD_RAND_OUT;
         default: return CMD_STATUS;
      endcase
   endfunction : firstCmd
   function automatic logic [7:0] secondCmd(op_e op);
      unique case (op)
         OP_READ: return CMD_READ_GO;
         OP_COPY_READ: return CMD_COPY_READ_GO;
         OP_PROGRAM, OP_COPY_PROGRAM: return CMD_PROGRAM_GO;
         OP_CACHE_PROGRAM: return CMD_CACHE_GO;
         OP_ERASE: return CMD_ERASE_GO;
         OP_RAND_OUT: return CMD_RAND_OUT_GO;
         default: return CMD_STATUS;
      endcase
   endfunction : secondCmd
   function automatic logic hasSecond(op_e op);
      return op inside {OP_READ, OP_COPY_READ, OP_PROGRAM,
         OP_CACHE_PROGRAM, OP_COPY_PROGRAM, OP_ERASE, OP_RAND_OUT};
   endfunction : hasSecond
   function automatic logic [2:0] addrCycles(op_e op);
      if (op inside {OP_READ, OP_COPY_READ, OP_PROGRAM,
            OP_CACHE_PROGRAM, OP_COPY_PROGRAM})
         return FULL_ADDR_CYCLES;
      if (op inside {OP_ERASE, OP_RAND_IN, OP_RAND_OUT})
         return HALF_ADDR_CYCLES;
      return 3'h0;
   endfunction : addrCycles
   function automatic logic writesData(op_e op);
      return op inside {OP_PROGRAM, OP_CACHE_PROGRAM, OP_RAND_IN};
   endfunction : writesData
   function automatic logic readsData(op_e op);
      return op inside {OP_READ, OP_COPY_READ, OP_READ_ID, OP_STATUS,
         OP_RAND_OUT};
   endfunction : readsData
   function automatic logic waitsBusy(op_e op);
      return op inside {OP_READ, OP_COPY_READ, OP_RESET, OP_PROGRAM,
         OP_CACHE_PROGRAM, OP_COPY_PROGRAM, OP_ERASE};
   endfunction : waitsBusy
   function automatic logic busyAllowed(op_e op);
      return op inside {OP_RESET, OP_STATUS};
   endfunction : busyAllowed
endpackage : nand_host_pkg

/* logic/nand_bus_cycle.sv */
// One strobed byte cycle on the NAND pins, write or read
module nand_bus_cycle #(
   parameter int LOW_CYC = 7,
   parameter int HIGH_CYC = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request
   input wire logic go,
   input wire nand_host_pkg::cycle_s cyc,
   output logic done,
   output logic [7:0] rdByte,
   // Pins
   output logic cle,
   output logic ale,
   output logic weN,
   output logic readStrobeLowN,
   output logic [7:0] ioOut,
   output logic ioOe,
   input wire logic [7:0] ioIn
);
   import nand_host_pkg::*;
   logic [7:0] cnt_q;
   logic low_q;
   logic high_q;
   logic rd_q;
   // ----------------------------------------------------------------
   // Strobe sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 8'h00;
         low_q <= 1'b0;
         high_q <= 1'b0;
         rd_q <= 1'b0;
         done <= 1'b0;
         rdByte <= 8'h00;
         cle <= 1'b0;
         ale <= 1'b0;
         weN <= 1'b1;
         readStrobeLowN <= 1'b1;
         ioOut <= 8'h00;
         ioOe <= 1'b0;
      end else begin
         done <= 1'b0;
         if (go && !low_q && !high_q) begin
            cle <= cyc.cle;
            ale <= cyc.ale;
            ioOut <= cyc.dat;
            ioOe <= !cyc.rd;
            rd_q <= cyc.rd;
            weN <= cyc.rd;
            readStrobeLowN <= !cyc.rd;
            low_q <= 1'b1;
            cnt_q <= 8'(LOW_CYC - 1);
         end else if (low_q) begin
            if (cnt_q == 8'h00) begin
               // Byte is sampled just before the read strobe rises
               if (rd_q)
                  rdByte <= ioIn;
               weN <= 1'b1;
               readStrobeLowN <= 1'b1;
               low_q <= 1'b0;
               high_q <= 1'b1;
               cnt_q <= 8'(HIGH_CYC - 1);
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end else if (high_q) begin
            if (cnt_q == 8'h00) begin
               high_q <= 1'b0;
               done <= 1'b1;
               cle <= 1'b0;
               ale <= 1'b0;
               ioOe <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end
   // Command latch and data stay put across the write strobe rising edge
   chk_hold_rise: assert property (@(posedge clk) disable iff (!nrst)
      $rose(weN) |-> ioOe && $stable(ioOut) && $stable(cle))
      else $error("write data or latch changed at strobe rise");
   chk_strobe_excl: assert property (@(posedge clk) disable iff (!nrst)
      !(!weN && !readStrobeLowN))
      else $error("write and read strobes low together");
endmodule : nand_bus_cycle

/* logic/nand_host_ctrl.sv */
// Host-side NAND flash command sequencer driving the device pins
module nand_host_ctrl #(
   parameter int LOW_CYC = nand_host_pkg::STROBE_LOW_CYC,
   parameter int HIGH_CYC = nand_host_pkg::STROBE_HIGH_CYC,
   parameter int SETTLE_CYC = nand_host_pkg::BUSY_SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Operation request
   input wire logic cmdValid,
   input wire nand_host_pkg::req_s cmdReq,
   output logic cmdReady,
   output logic opDone,
   input wire logic writeAllow,
   // Program data stream
   input wire logic wrValid,
   input wire logic [7:0] wrData,
   output logic wrReady,
   // Read data stream
   output logic rdValid,
   output logic [7:0] rdData,
   // Device pins
   output logic ceN,
   output logic cle,
   output logic ale,
   output logic weN,
   output logic readStrobeLowN,
   output logic wpN,
   output logic [7:0] ioOut,
   output logic ioOe,
   input wire logic [7:0] ioIn,
   input wire logic rbN
);
   import nand_host_pkg::*;
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_CMD1 = 7'b0000010,
      S_ADDR = 7'b0000100,
      S_WDATA = 7'b0001000,
      S_CMD2 = 7'b0010000,
      S_WAITB = 7'b0100000,
      S_RDATA = 7'b1000000
   } state_e;
   state_e state_q;
   req_s req_q;
   cycle_s cyc_q;
   logic go_q;
   logic inFlight_q;
   logic [LEN_W-1:0] cnt_q;
   logic done;
   logic [7:0] rdByte;
   logic accept;
   logic launchOk;
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Skips the phases that the operation does not use
   function automatic state_e after(state_e s, req_s r);
      if (s == S_CMD1 && addrCycles(r.op) != 3'h0)
         return S_ADDR;
      if (s inside {S_CMD1, S_ADDR} && writesData(r.op) &&
            r.length != '0)
         return S_WDATA;
      if (s inside {S_CMD1, S_ADDR, S_WDATA} && hasSecond(r.op))
         return S_CMD2;
      if (s inside {S_CMD1, S_ADDR, S_WDATA, S_CMD2} && waitsBusy(r.op))
         return S_WAITB;
      if (s != S_RDATA && readsData(r.op) && r.length != '0)
         return S_RDATA;
      return S_IDLE;
   endfunction : after
   // Column first, then row, low byte first; unused high bits low
   function automatic logic [7:0] addrByte(req_s r, logic [LEN_W-1:0] i);
      logic [1:0] k;
      k = (r.op == OP_ERASE) ? 2'(i + 2) : i[1:0];
      unique case (k)
         2'h0: return r.column[7:0];
         2'h1: return {4'h0, r.column[COL_W-1:8]};
         2'h2: return r.row[7:0];
         default: return r.row[ROW_W-1:8];
      endcase
   endfunction : addrByte
   // Only reset and status may go out while the device is busy
   assign accept = cmdValid && cmdReady &&
      (rbN || busyAllowed(cmdReq.op));
   assign launchOk = !inFlight_q && !go_q;
   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         req_q <= '0;
         cyc_q <= '0;
         go_q <= 1'b0;
         inFlight_q <= 1'b0;
         cnt_q <= '0;
         cmdReady <= 1'b1;
         opDone <= 1'b0;
         wrReady <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 8'h00;
         ceN <= 1'b1;
      end else begin
         go_q <= 1'b0;
         opDone <= 1'b0;
         rdValid <= 1'b0;
         if (done)
            inFlight_q <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (accept) begin
                  req_q <= cmdReq;
                  cmdReady <= 1'b0;
                  ceN <= 1'b0;
                  cnt_q <= '0;
                  state_q <= S_CMD1;
               end
            end
            S_CMD1: begin
               if (launchOk && !done) begin
                  // Only table codes leave this block
                  cyc_q <= '{1'b1, 1'b0, 1'b0, firstCmd(req_q.op)};
                  go_q <= 1'b1;
                  inFlight_q <= 1'b1;
               end else if (done) begin
                  state_q <= after(S_CMD1, req_q);
               end
            end
            S_ADDR: begin
               if (launchOk && !done) begin
                  cyc_q <= '{1'b0, 1'b1, 1'b0, addrByte(req_q, cnt_q)};
                  go_q <= 1'b1;
                  inFlight_q <= 1'b1;
               end else if (done) begin
                  if (cnt_q == LEN_W'(addrCycles(req_q.op) - 3'h1)) begin
                     cnt_q <= '0;
                     state_q <= after(S_ADDR, req_q);
                  end else begin
                     cnt_q <= cnt_q + 1'b1;
                  end
               end
            end
            S_WDATA: begin
               if (launchOk && !done && !wrReady && cnt_q != req_q.length)
                  wrReady <= 1'b1;
               if (wrReady && wrValid) begin
                  wrReady <= 1'b0;
                  cyc_q <= '{1'b0, 1'b0, 1'b0, wrData};
                  go_q <= 1'b1;
                  inFlight_q <= 1'b1;
                  cnt_q <= cnt_q + 1'b1;
               end else if (done && cnt_q == req_q.length) begin
                  cnt_q <= '0;
                  state_q <= after(S_WDATA, req_q);
               end
            end
            S_CMD2: begin
               if (launchOk && !done) begin
                  cyc_q <= '{1'b1, 1'b0, 1'b0, secondCmd(req_q.op)};
                  go_q <= 1'b1;
                  inFlight_q <= 1'b1;
               end else if (done) begin
                  state_q <= after(S_CMD2, req_q);
               end
            end
            S_WAITB: begin
               // The ready line only drops some time after the confirm
               if (cnt_q != LEN_W'(SETTLE_CYC))
                  cnt_q <= cnt_q + 1'b1;
               else if (rbN) begin
                  cnt_q <= '0;
                  state_q <= after(S_WAITB, req_q);
               end
            end
            S_RDATA: begin
               if (launchOk && !done) begin
                  cyc_q <= '{1'b0, 1'b0, 1'b1, 8'h00};
                  go_q <= 1'b1;
                  inFlight_q <= 1'b1;
               end else if (done) begin
                  rdValid <= 1'b1;
                  rdData <= rdByte;
                  cnt_q <= cnt_q + 1'b1;
                  if (cnt_q == req_q.length - 1'b1)
                     state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
         // One end test keeps state, select and done in step
         if (state_q_next_idle()) begin
            state_q <= S_IDLE;
            cmdReady <= 1'b1;
            opDone <= 1'b1;
            ceN <= 1'b1;
         end
      end
   end
   // True in the cycle in which the sequencer returns to idle
   function automatic logic state_q_next_idle();
      unique case (state_q)
         S_WAITB:
            return cnt_q == LEN_W'(SETTLE_CYC) && rbN &&
               after(S_WAITB, req_q) == S_IDLE;
         S_ADDR:
            return done &&
               cnt_q == LEN_W'(addrCycles(req_q.op) - 3'h1) &&
               after(S_ADDR, req_q) == S_IDLE;
         S_RDATA:
            return done && cnt_q == req_q.length - 1'b1;
         S_WDATA:
            return done && cnt_q == req_q.length &&
               after(S_WDATA, req_q) == S_IDLE;
         S_IDLE:
            return 1'b0;
         default:
            return done && after(state_q, req_q) == S_IDLE;
      endcase
   endfunction : state_q_next_idle
   // ----------------------------------------------------------------
   // Write guard
   // ----------------------------------------------------------------
   // Guard is registered so the pin never glitches on the input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         wpN <= 1'b0;
      else
         wpN <= writeAllow;
   end
   nand_bus_cycle #(
      .LOW_CYC(LOW_CYC),
      .HIGH_CYC(HIGH_CYC)
   ) uCycle (
      .clk(clk),
      .nrst(nrst),
      .go(go_q),
      .cyc(cyc_q),
      .done(done),
      .rdByte(rdByte),
      .cle(cle),
      .ale(ale),
      .weN(weN),
      .readStrobeLowN(readStrobeLowN),
      .ioOut(ioOut),
      .ioOe(ioOe),
      .ioIn(ioIn)
   );
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_busy_gate: assert property (cmdValid && cmdReady && !rbN &&
      !busyAllowed(cmdReq.op) |=> cmdReady && ceN)
      else $error("array command issued while busy");
   chk_select_low: assert property (state_q != S_IDLE |-> !ceN)
      else $error("device deselected during an operation");
   chk_first_cmd: assert property (go_q && state_q == S_CMD1 |->
      cyc_q.cle && !cyc_q.ale && cyc_q.dat == firstCmd(req_q.op))
      else $error("first command byte wrong");
   chk_addr_latch: assert property (go_q && state_q == S_ADDR |->
      ##1 (ale && !cle) [*3])
      else $error("address cycle without address latch");
   chk_col_pad: assert property (go_q && state_q == S_ADDR &&
      req_q.op != OP_ERASE && cnt_q == 1 |-> cyc_q.dat[7:4] == 4'h0)
      else $error("unused column bits not low");
   chk_addr_count: assert property ($fell(state_q == S_ADDR) |->
      $past(cnt_q) == LEN_W'(addrCycles(req_q.op) - 3'h1))
      else $error("wrong number of address cycles");
   chk_erase_row: assert property (go_q && state_q == S_ADDR &&
      req_q.op == OP_ERASE && cnt_q == 0 |-> cyc_q.dat == req_q.row[7:0])
      else $error("erase did not start with row byte");
   chk_confirm: assert property (go_q && state_q == S_CMD2 |->
      cyc_q.cle && cyc_q.dat == secondCmd(req_q.op))
      else $error("confirm byte wrong");
   chk_read_wait: assert property ($rose(state_q == S_RDATA) &&
      waitsBusy(req_q.op) |-> $past(rbN))
      else $error("data read before ready");
   cov_program: cover property (opDone && req_q.op == OP_PROGRAM);
   cov_read: cover property (opDone && req_q.op == OP_READ);
   cov_erase: cover property (opDone && req_q.op == OP_ERASE);
   cov_busy_status: cover property (accept && !rbN &&
      cmdReq.op == OP_STATUS);
endmodule : nand_host_ctrl

/* tb/nand_dev_model.sv */
// Behavioural NAND device model on the far side of the host controller
module nand_dev_model #(
   parameter int BUSY_CYC = 20
) (
   // Clock
   input wire logic clk,
   // Pins from the host
   input wire logic ceN,
   input wire logic cle,
   input wire logic ale,
   input wire logic weN,
   input wire logic readStrobeLowN,
   input wire logic wpN,
   input wire logic [7:0] ioOut,
   // Pins to the host
   output logic [7:0] ioDev,
   output logic rbN,
   // Scenario control
   input wire logic holdBusy
);
   // ----------------------------------------------------------------
   // Capture and busy
   // ----------------------------------------------------------------
   logic [9:0] logQ[$];
   logic [11:0] col = 12'h000;
   int nAddr = 0;
   int busyCnt = 0;
   initial ioDev = 8'h00;
   // Busy counts on regardless of select
   assign rbN = !(busyCnt > 0 || holdBusy);
   always @(posedge clk) if (busyCnt > 0) busyCnt <= busyCnt - 1;
   always @(posedge weN) begin
      if (!ceN && cle && (rbN || ioOut inside {8'hff, 8'h70})) begin
         logQ.push_back({2'b10, ioOut});
         nAddr = 0;
         if (ioOut inside {8'h30, 8'h35, 8'hff}) busyCnt = BUSY_CYC;
         // Guard low keeps program and erase from ever starting
         if (wpN && ioOut inside {8'h10, 8'h15, 8'hd0})
            busyCnt = BUSY_CYC;
         if (ioOut inside {8'h70, 8'h90}) col = 12'h000;
      end else if (!ceN && ale && rbN) begin
         logQ.push_back({2'b01, ioOut});
         if (nAddr == 0) col[7:0] = ioOut;
         if (nAddr == 1) col[11:8] = ioOut[3:0];
         nAddr++;
      end else if (!ceN && rbN) begin
         logQ.push_back({2'b00, ioOut});
      end
   end
   always @(negedge readStrobeLowN) begin
      if (!ceN) begin
         ioDev = col[7:0] ^ 8'h5a;
         col++;
      end
   end
   // Hold time over: never leave the last byte standing
   always @(posedge readStrobeLowN) ioDev <= #1 ~ioDev;
endmodule : nand_dev_model

/* tb/nand_host_ctrl_tb.sv */
// Self-checking bench of the NAND host controller
module nand_host_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import nand_host_pkg::*;
   logic clk, nrst, cmdValid, cmdReady, opDone, writeAllow, wrValid;
   logic wrReady, rdValid, ceN, cle, ale, weN, readStrobeLowN, wpN;
   logic ioOe, rbN, holdBusy;
   logic [7:0] wrData, rdData, ioOut, ioDev;
   req_s cmdReq;
   wire logic [7:0] ioBus = ioOe ? ioOut : ioDev;
   logic [7:0] rdQ[$];
   int n_errors = 0;
   int n_compared = 0;
   nand_host_ctrl #(.SETTLE_CYC(2)) i_dut (.clk(clk), .nrst(nrst),
      .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady),
      .opDone(opDone), .writeAllow(writeAllow), .wrValid(wrValid),
      .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid),
      .rdData(rdData), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
      .readStrobeLowN(readStrobeLowN), .wpN(wpN), .ioOut(ioOut),
      .ioOe(ioOe), .ioIn(ioBus), .rbN(rbN));
   nand_dev_model i_dev (.clk(clk), .ceN(ceN), .cle(cle), .ale(ale),
      .weN(weN), .readStrobeLowN(readStrobeLowN), .wpN(wpN),
      .ioOut(ioOut), .ioDev(ioDev), .rbN(rbN), .holdBusy(holdBusy));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   function automatic logic [9:0] cb(logic [7:0] b);
      return {2'b10, b};
   endfunction : cb
   function automatic logic [9:0] ab(logic [7:0] b);
      return {2'b01, b};
   endfunction : ab
   task automatic finish_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic check(string what, logic [9:0] exp, logic [9:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic check_log(logic [9:0] exp[$]);
      check("log size", 10'(exp.size()), 10'(i_dev.logQ.size()));
      foreach (exp[i]) check("bus byte", exp[i], i_dev.logQ[i]);
   endtask : check_log
   task automatic check_rd(logic [7:0] exp[$]);
      check("read count", 10'(exp.size()), 10'(rdQ.size()));
      foreach (exp[i]) check("read byte", {2'b00, exp[i]}, {2'b00, rdQ[i]});
   endtask : check_rd
   task automatic run_op(op_e op, logic [11:0] c, logic [15:0] r,
         logic [11:0] len);
      int n;
      int k;
      logic take;
      k = 0;
      take = 1'b0;
      // Let an edge pass so valid never drops and rises in one step
      @(negedge clk);
      rdQ.delete();
      i_dev.logQ.delete();
      cmdReq = '{op, c, r, len};
      cmdValid = 1'b1;
      wrValid = 1'b1;
      for (n = 0; n < 5000; n++) begin
         @(negedge clk);
         if (cmdReady === 1'b0) cmdValid = 1'b0;
         if (take) k++;
         take = wrReady;
         wrData = 8'h3c + 8'(k);
         if (rdValid === 1'b1) rdQ.push_back(rdData);
         if (opDone === 1'b1) break;
      end
      cmdValid = 1'b0;
      wrValid = 1'b0;
      if (n == 5000) begin
         check("op done", 10'h001, {9'h0, opDone});
         finish_test();
      end
      // A held-busy device keeps the ready line low past a status read
      check("ready at end", {9'h0, !holdBusy}, {9'h0, rbN});
   endtask : run_op
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic sc_program();
      run_op(OP_PROGRAM, 12'h823, 16'ha5c3, 12'h002);
      check_log({cb(8'h80), ab(8'h23), ab(8'h08), ab(8'hc3), ab(8'ha5),
         10'h03c, 10'h03d, cb(8'h10)});
      run_op(OP_CACHE_PROGRAM, 12'h000, 16'hffff, 12'h001);
      check_log({cb(8'h80), ab(8'h00), ab(8'h00), ab(8'hff), ab(8'hff),
         10'h03c, cb(8'h15)});
      run_op(OP_COPY_PROGRAM, 12'h840, 16'h0102, 12'h000);
      check_log({cb(8'h85), ab(8'h40), ab(8'h08), ab(8'h02),
         ab(8'h01), cb(8'h10)});
   endtask : sc_program
   task automatic sc_read();
      run_op(OP_READ, 12'h83f, 16'h0001, 12'h003);
      check_log({cb(8'h00), ab(8'h3f), ab(8'h08), ab(8'h01), ab(8'h00),
         cb(8'h30)});
      check_rd({8'h3f ^ 8'h5a, 8'h40 ^ 8'h5a, 8'h41 ^ 8'h5a});
      run_op(OP_COPY_READ, 12'h001, 16'h8000, 12'h000);
      check_log({cb(8'h00), ab(8'h01), ab(8'h00), ab(8'h00), ab(8'h80),
         cb(8'h35)});
   endtask : sc_read
   task automatic sc_erase_guard();
      run_op(OP_ERASE, 12'h000, 16'h7e40, 12'h000);
      check_log({cb(8'h60), ab(8'h40), ab(8'h7e), cb(8'hd0)});
      writeAllow = 1'b0;
      repeat (2) @(negedge clk);
      check("guard pin", 10'h000, {9'h0, wpN});
      run_op(OP_ERASE, 12'h000, 16'h0040, 12'h000);
      check("busy count", 10'h000, 10'(i_dev.busyCnt));
      writeAllow = 1'b1;
      repeat (2) @(negedge clk);
      check("guard pin", 10'h001, {9'h0, wpN});
   endtask : sc_erase_guard
   task automatic sc_single();
      run_op(OP_RESET, 12'h000, 16'h0000, 12'h000);
      check_log({cb(8'hff)});
      run_op(OP_READ_ID, 12'h000, 16'h0000, 12'h002);
      check_log({cb(8'h90)});
      check_rd({8'h5a, 8'h5b});
      run_op(OP_RAND_OUT, 12'h805, 16'h0000, 12'h001);
      check_log({cb(8'h05), ab(8'h05), ab(8'h08), cb(8'he0)});
      check_rd({8'h5f});
      run_op(OP_RAND_IN, 12'h010, 16'h0000, 12'h001);
      check_log({cb(8'h85), ab(8'h10), ab(8'h00), 10'h03c});
   endtask : sc_single
   task automatic sc_busy();
      @(negedge clk);
      holdBusy = 1'b1;
      cmdReq = '{OP_READ, 12'h000, 16'h0000, 12'h001};
      cmdValid = 1'b1;
      repeat (10) @(negedge clk);
      check("refused ready", 10'h001, {9'h0, cmdReady});
      check("refused select", 10'h001, {9'h0, ceN});
      run_op(OP_STATUS, 12'h000, 16'h0000, 12'h001);
      check_log({cb(8'h70)});
      holdBusy = 1'b0;
      @(negedge clk);
   endtask : sc_busy
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      nrst = 1'b0;
      cmdValid = 1'b0;
      cmdReq = '0;
      writeAllow = 1'b1;
      wrValid = 1'b0;
      wrData = 8'h00;
      holdBusy = 1'b0;
      repeat (8) @(negedge clk);
      check("idle select", 10'h001, {9'h0, ceN});
      check("idle drive", 10'h000, {9'h0, ioOe});
      nrst = 1'b1;
      sc_program();
      sc_read();
      sc_erase_guard();
      sc_single();
      sc_busy();
      finish_test();
   end
endmodule : nand_host_ctrl_tb
